/* File: core/ierr_edge_detect.sv */
// rising-edge detector for the unreliable-link level flag
`default_nettype none
module ierr_edge_detect
  import ierr_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // level in, pulse out
  input  wire logic level_i,
  output logic      rise_o
);
  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t state_q;
  edge_state_t state_d;

  always_comb begin
    state_d      = state_q;
    state_d.prev = level_i;
  end

  assign rise_o = level_i & ~state_q.prev;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end
endmodule
`default_nettype wire

/* File: core/ierr_pkg.sv */
// package: register map, field positions and reset values of the internal error bank
`default_nettype none
package ierr_pkg;
  localparam logic [11:0] CTRL_OFFSET    = 12'h480;
  localparam logic [11:0] STATUS_OFFSET  = 12'h484;
  localparam logic [11:0] MASK_OFFSET    = 12'h488;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
  localparam int          EVENT_COUNT    = 19;
  localparam logic [18:0] EVENT_BITS     = 19'h7FFF7;
  localparam int          REPORT_EN_BIT  = 0;
  localparam int          BIT_IN_POSTED  = 0;
  localparam int          BIT_IN_NONPOST = 1;
  localparam int          BIT_IN_CPL     = 2;
  localparam int          BIT_OUT_POSTED = 4;
  localparam int          BIT_OUT_NONPOST= 5;
  localparam int          BIT_OUT_CPL    = 6;
  localparam int          BIT_IN_DAT_SBE = 7;
  localparam int          BIT_IN_DAT_DBE = 8;
  localparam int          BIT_IN_CTL_SBE = 9;
  localparam int          BIT_IN_CTL_DBE = 10;
  localparam int          BIT_OUT_DAT_SBE= 11;
  localparam int          BIT_OUT_DAT_DBE= 12;
  localparam int          BIT_OUT_CTL_SBE= 13;
  localparam int          BIT_OUT_CTL_DBE= 14;
  localparam int          BIT_PARITY     = 15;
  localparam int          BIT_UNRELIABLE = 16;
  localparam int          BIT_RPL_SBE    = 17;
  localparam int          BIT_RPL_DBE    = 18;
endpackage
`default_nettype wire

/* File: core/internal_error_status_mask.sv */
// internal error status/mask register bank with classic wishbone slave
// Functional notes
// - inbound buffer timeouts set bits 0-2
// - outbound buffer timeouts set bits 4-6
// - inbound data RAM ECC sets 7, 8
// - inbound control RAM ECC sets 9, 10
// - outbound data RAM ECC sets 11, 12
// - outbound control RAM ECC sets 13, 14
// - datapath parity error sets bit 15
// - unreliable link flag rising sets 16
// - replay control RAM ECC sets 17, 18
// - status at 0x484, sticky, write-one clears
// - mask at 0x488, read-write, resets zero
// - set mask bit blocks its report
// - status records events regardless of mask
// - report output only while control bit 0 set, unmasked vector ungated
// - mask bit for every event bit
`default_nettype none
module internal_error_status_mask
  import ierr_pkg::*;
(
  // clock and fundamental reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // error detector pulses and the unreliable link flag level
  input  wire logic        inbound_posted_timeout_i,
  input  wire logic        inbound_nonposted_timeout_i,
  input  wire logic        inbound_completion_timeout_i,
  input  wire logic        outbound_posted_timeout_i,
  input  wire logic        outbound_nonposted_timeout_i,
  input  wire logic        outbound_completion_timeout_i,
  input  wire logic        inbound_data_single_ecc_i,
  input  wire logic        inbound_data_double_ecc_i,
  input  wire logic        inbound_ctrl_single_ecc_i,
  input  wire logic        inbound_ctrl_double_ecc_i,
  input  wire logic        outbound_data_single_ecc_i,
  input  wire logic        outbound_data_double_ecc_i,
  input  wire logic        outbound_ctrl_single_ecc_i,
  input  wire logic        outbound_ctrl_double_ecc_i,
  input  wire logic        datapath_parity_error_i,
  input  wire logic        unreliable_link_flag_i,
  input  wire logic        replay_ctrl_single_ecc_i,
  input  wire logic        replay_ctrl_double_ecc_i,
  // towards AER reporting
  output logic             internal_error_report_o,
  output logic      [31:0] internal_error_unmasked_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] status;
    logic [31:0] mask;
    logic        report;
    logic [31:0] unmasked;
  } bank_state_t;

  bank_state_t state_q;
  bank_state_t state_d;

  logic        link_rise;
  logic [31:0] events;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic [31:0] valid_bits;
  logic        wr_strobe;
  logic        rd_strobe;
  logic [31:0] pending;

  // link flag is a level; only its setting counts as an event
  ierr_edge_detect u_link_edge (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .level_i   (unreliable_link_flag_i),
    .rise_o    (link_rise)
  );

  assign valid_bits = {13'h0000, EVENT_BITS};

  always_comb begin
    events = '0;
    events[BIT_IN_POSTED]   = inbound_posted_timeout_i;
    events[BIT_IN_NONPOST]  = inbound_nonposted_timeout_i;
    events[BIT_IN_CPL]      = inbound_completion_timeout_i;
    events[BIT_OUT_POSTED]  = outbound_posted_timeout_i;
    events[BIT_OUT_NONPOST] = outbound_nonposted_timeout_i;
    events[BIT_OUT_CPL]     = outbound_completion_timeout_i;
    events[BIT_IN_DAT_SBE]  = inbound_data_single_ecc_i;
    events[BIT_IN_DAT_DBE]  = inbound_data_double_ecc_i;
    events[BIT_IN_CTL_SBE]  = inbound_ctrl_single_ecc_i;
    events[BIT_IN_CTL_DBE]  = inbound_ctrl_double_ecc_i;
    events[BIT_OUT_DAT_SBE] = outbound_data_single_ecc_i;
    events[BIT_OUT_DAT_DBE] = outbound_data_double_ecc_i;
    events[BIT_OUT_CTL_SBE] = outbound_ctrl_single_ecc_i;
    events[BIT_OUT_CTL_DBE] = outbound_ctrl_double_ecc_i;
    events[BIT_PARITY]      = datapath_parity_error_i;
    events[BIT_UNRELIABLE]  = link_rise;
    events[BIT_RPL_SBE]     = replay_ctrl_single_ecc_i;
    events[BIT_RPL_DBE]     = replay_ctrl_double_ecc_i;
  end

  // byte lanes expanded from sel
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  assign wdata     = wb_dat_i & wmask;
  // single-cycle ack; the idle cycle after ack keeps one request from acking twice
  assign wr_strobe = wb_cyc_i & wb_stb_i & wb_we_i & ~state_q.ack;
  assign rd_strobe = wb_cyc_i & wb_stb_i & ~wb_we_i & ~state_q.ack;

  always_comb begin
    state_d       = state_q;
    state_d.ack   = wb_cyc_i & wb_stb_i & ~state_q.ack;
    state_d.rdata = '0;

    // write-one clears, then new events set
    if (wr_strobe && wb_adr_i == STATUS_OFFSET) begin
      state_d.status = state_q.status & ~wdata;
    end
    // set wins over clear, mask not consulted
    state_d.status = (state_d.status | events) & valid_bits;

    if (wr_strobe && wb_adr_i == MASK_OFFSET) begin
      // one mask bit per event bit
      state_d.mask = (state_q.mask & ~wmask) | (wdata & valid_bits);
    end
    state_d.mask = state_d.mask & valid_bits;

    if (wr_strobe && wb_adr_i == CTRL_OFFSET) begin
      state_d.ctrl[REPORT_EN_BIT] = wmask[REPORT_EN_BIT] ? wb_dat_i[REPORT_EN_BIT]
                                                         : state_q.ctrl[REPORT_EN_BIT];
    end

    if (rd_strobe) begin
      unique case (wb_adr_i)
        CTRL_OFFSET:   state_d.rdata = state_q.ctrl;
        STATUS_OFFSET: state_d.rdata = state_q.status;
        MASK_OFFSET:   state_d.rdata = state_q.mask;
        default:       state_d.rdata = '0;
      endcase
    end

    pending          = state_q.status & ~state_q.mask;
    state_d.unmasked = pending;
    state_d.report   = state_q.ctrl[REPORT_EN_BIT] & (|pending);
  end

  // only the fundamental reset clears sticky state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q.ack      <= 1'b0;
      state_q.rdata    <= '0;
      state_q.ctrl     <= CTRL_RESET;
      state_q.status   <= STATUS_RESET;
      state_q.mask     <= MASK_RESET;
      state_q.report   <= 1'b0;
      state_q.unmasked <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign wb_ack_o                  = state_q.ack;
  assign wb_dat_o                  = state_q.rdata;
  assign internal_error_report_o   = state_q.report;
  assign internal_error_unmasked_o = state_q.unmasked;

endmodule
`default_nettype wire

/* File: testbench/err_detect_model.sv */
// model of the error detectors feeding the bank
`default_nettype none
module err_detect_model
  import ierr_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic [18:0] fire_i,
  output logic      [18:0] ev_o
);
  // link flag is a level; it falls again so every rise is fresh
  always_ff @(posedge clk_sys_i) begin
    ev_o <= fire_i & EVENT_BITS;
  end
endmodule
`default_nettype wire

/* File: testbench/ierr_monitor.sv */
// checker: bus and reporting relations of the internal error bank
`default_nettype none
module ierr_monitor
  import ierr_pkg::*;
(
  input wire logic        clk_sys_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic        wb_ack_o, internal_error_report_o,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o, internal_error_unmasked_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_resv_read: assert property (wb_ack_o |-> wb_dat_o[31:19] == 13'h0 && !wb_dat_o[3])
    else $error("reserved bits read nonzero");
  chk_unm_resv: assert property (internal_error_unmasked_o[31:19] == 13'h0)
    else $error("unmasked reserved bit");
  chk_report_cause: assert property (internal_error_report_o |->
    internal_error_unmasked_o != 32'h0) else $error("report with nothing unmasked");
  // sticky: a bit only drops after a bus write
  chk_sticky_hold: assert property (!$past(wb_cyc_i && wb_we_i) |->
    ($past(internal_error_unmasked_o) & ~internal_error_unmasked_o) == 32'h0)
    else $error("status bit lost without write");
  cover property (wb_ack_o && $past(wb_we_i));
  cover property ($rose(internal_error_report_o));
  cover property (!internal_error_report_o && internal_error_unmasked_o != 32'h0);
endmodule
bind internal_error_status_mask ierr_monitor ierr_monitor_inst (.clk_sys_i, .rst_n_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .internal_error_report_o, .wb_adr_i,
  .wb_dat_o, .internal_error_unmasked_o);
`default_nettype wire

/* File: testbench/internal_error_status_mask_bench.sv */
// self-checking bench of the internal error bank
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
  $display("BAD %s expected %h seen %h", n, e, s); end end
module internal_error_status_mask_bench
  import ierr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, ack, report;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0, rdat, unm, q, mk, st;
  logic [18:0] fire = 19'h0, ev;
  int          num_errors = 0, tests_run = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  err_detect_model err_detect_model_inst (.clk_sys_i, .fire_i(fire), .ev_o(ev));
  internal_error_status_mask internal_error_status_mask_inst (.clk_sys_i, .rst_n_i,
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .inbound_posted_timeout_i(ev[0]), .inbound_nonposted_timeout_i(ev[1]),
    .inbound_completion_timeout_i(ev[2]), .outbound_posted_timeout_i(ev[4]),
    .outbound_nonposted_timeout_i(ev[5]), .outbound_completion_timeout_i(ev[6]),
    .inbound_data_single_ecc_i(ev[7]), .inbound_data_double_ecc_i(ev[8]),
    .inbound_ctrl_single_ecc_i(ev[9]), .inbound_ctrl_double_ecc_i(ev[10]),
    .outbound_data_single_ecc_i(ev[11]), .outbound_data_double_ecc_i(ev[12]),
    .outbound_ctrl_single_ecc_i(ev[13]), .outbound_ctrl_double_ecc_i(ev[14]),
    .datapath_parity_error_i(ev[15]), .unreliable_link_flag_i(ev[16]),
    .replay_ctrl_single_ecc_i(ev[17]), .replay_ctrl_double_ecc_i(ev[18]),
    .internal_error_report_o(report), .internal_error_unmasked_o(unm));
  // one classic cycle; read data taken at the ack edge
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    // no local limit: only the watchdog ends a hung wait
    do begin @(posedge clk_sys_i); end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic fire_ev(input logic [18:0] v);
    fire <= v;
    @(posedge clk_sys_i);
    fire <= 19'h0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  function automatic logic [31:0] exp_unm(logic [31:0] s, logic [31:0] m);
    return s & ~m & {13'h0, EVENT_BITS};
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(79));
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    bus(CTRL_OFFSET, 0, 0);   `CHK("ctrl", 32'h1, q)
    bus(STATUS_OFFSET, 0, 0); `CHK("status", 32'h0, q)
    bus(MASK_OFFSET, 0, 0);   `CHK("mask", 32'h0, q)
    bus(12'h48C, 1, '1);
    bus(12'h48C, 0, 0);       `CHK("unmapped", 32'h0, q)
    $display("test reset values done");
    for (int i = 0; i < 19; i++) if (EVENT_BITS[i]) begin
      fire_ev(19'h1 << i);
      bus(STATUS_OFFSET, 0, 0); `CHK("event", 32'h1 << i, q)
      `CHK("report", 1'b1, report)
      bus(STATUS_OFFSET, 1, '1);
      bus(STATUS_OFFSET, 0, 0); `CHK("clear", 32'h0, q)
    end
    $display("test single events done");
    repeat (6) begin
      mk = $urandom();
      st = $urandom() & {13'h0, EVENT_BITS};
      bus(MASK_OFFSET, 1, mk);
      bus(MASK_OFFSET, 0, 0); `CHK("mask", mk & {13'h0, EVENT_BITS}, q)
      fire_ev(st[18:0]);
      bus(STATUS_OFFSET, 0, 0); `CHK("sticky", st, q)
      `CHK("unmasked", exp_unm(st, mk), unm)
      `CHK("report", |exp_unm(st, mk), report)
      bus(CTRL_OFFSET, 1, 0); `CHK("disabled", 1'b0, report)
      bus(CTRL_OFFSET, 1, 1);
      bus(STATUS_OFFSET, 1, '1);
    end
    $display("test masking done");
    fire_ev(19'h7FFF7);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    bus(STATUS_OFFSET, 0, 0); `CHK("status rst", 32'h0, q)
    bus(MASK_OFFSET, 0, 0);   `CHK("mask rst", 32'h0, q)
    $display("test fundamental reset done");
    end_of_test;
  end
endmodule
`undef CHK
`default_nettype wire
